/* File: design/lcd_device.sv */
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module lcd_device
   import lcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   lcd_bus_if.device bus,
   output logic display_on_o,
   output logic all_lit_o,
   output logic inverse_o,
   output logic seg_reverse_o,
   output logic com_reverse_o,
   output logic power_save_o,
   output logic osc_run_o,
   output logic outputs_ground_o,
   output logic stepup_on_o,
   output logic regulator_on_o,
   output logic follower_on_o,
   output logic [3:0] divider_ratio_o,
   output logic [4:0] gain_half_o,
   output logic [5:0] pot_value_o,
   output logic [5:0] pot_index_o,
   output logic pot_locked_o,
   output logic [1:0] ref_coef_o,
   output logic [2:0] stepup_factor_o,
   output logic [6:0] duty_lines_o,
   output logic rmw_mode_o,
   output logic test_mode_o,
   output logic [6:0] scan_line_o,
   output logic [6:0] scan_com_o
);
   logic [7:0] ram [0:RAM_WORDS-1]; // Display RAM, page major
   lcd_op_e op;                    // Decoded command
   logic cmd_wr;                   // Command write strobe
   logic data_wr;                  // Display data write
   logic data_rd;                  // Display data read
   logic stat_rd;                  // Status read
   logic [2:0] power_bits;         // Boost, regulator, follower
   logic [3:0] duty_code;
   logic [6:0] start_line;
   logic [6:0] start_com;
   logic [3:0] page;
   logic [7:0] col;
   logic [7:0] col_saved;          // Column at read/modify/write entry
   logic [7:0] read_latch;         // One read behind, hence dummy read
   logic [10:0] ram_idx;
   logic page_ok;
   logic [4:0] tick_cnt;
   logic tick;

   assign cmd_wr = bus.wr_stb && !bus.register_select;
   assign data_wr = bus.wr_stb && bus.register_select;
   assign data_rd = bus.rd_stb && bus.register_select;
   assign stat_rd = bus.rd_stb && !bus.register_select;
   assign page_ok = page < 4'(NUM_PAGES);
   assign ram_idx = 11'(page * NUM_COLS) + {3'h0, col};

   // Command decode; a locked pot takes any command byte as value
   always_comb begin
      op = LCD_OP_NONE;
      if (cmd_wr && pot_locked_o) begin
         op = LCD_OP_POT_VAL;
      end else if (cmd_wr) begin
         casez (bus.wdata)
            PAT_COL_LO: op = LCD_OP_COL_LO;
            PAT_COL_HI: op = LCD_OP_COL_HI;
            PAT_RATIO: op = LCD_OP_RATIO;
            PAT_POWER: op = LCD_OP_POWER;
            PAT_REF: op = LCD_OP_REF;
            PAT_STEPUP: op = LCD_OP_STEPUP;
            PAT_LINE_HI: op = LCD_OP_LINE_HI;
            PAT_LINE_LO: op = LCD_OP_LINE_LO;
            PAT_COM_HI: op = LCD_OP_COM_HI;
            PAT_COM_LO: op = LCD_OP_COM_LO;
            PAT_POT_MODE: op = LCD_OP_POT_MODE;
            PAT_DUTY: op = LCD_OP_DUTY;
            PAT_SEG: op = LCD_OP_SEG;
            PAT_ALL: op = LCD_OP_ALL;
            PAT_INV: op = LCD_OP_INV;
            PAT_DISP: op = LCD_OP_DISP;
            PAT_PAGE: op = LCD_OP_PAGE;
            PAT_COMDIR: op = LCD_OP_COMDIR;
            PAT_RMW: op = LCD_OP_RMW;
            PAT_RESET: op = LCD_OP_RESET;
            PAT_NOP: op = LCD_OP_NOP;
            PAT_END: op = LCD_OP_END;
            PAT_TEST: op = LCD_OP_TEST;
            default: op = LCD_OP_NONE;
         endcase
      end
   end

   // Display mode flags, kept through power save
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         display_on_o <= 1'b0;
         all_lit_o <= 1'b0;
         inverse_o <= 1'b0;
         seg_reverse_o <= 1'b0;
         com_reverse_o <= 1'b0;
      end else begin
         case (op)
            LCD_OP_DISP: display_on_o <= bus.wdata[0];
            LCD_OP_ALL: all_lit_o <= bus.wdata[0];
            LCD_OP_INV: inverse_o <= bus.wdata[0];
            LCD_OP_SEG: seg_reverse_o <= bus.wdata[0];
            LCD_OP_COMDIR: com_reverse_o <= bus.wdata[COMDIR_BIT];
            LCD_OP_RESET: com_reverse_o <= 1'b0;
            default: ;
         endcase
      end
   end

   // Supply settings: power bits, ratio, reference, boost, duty
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         power_bits <= 3'h0;
         divider_ratio_o <= RATIO_RESET;
         ref_coef_o <= 2'h0;
         stepup_factor_o <= 3'h0;
         duty_code <= DUTY_RESET;
      end else begin
         case (op)
            LCD_OP_POWER: power_bits <= bus.wdata[2:0];
            LCD_OP_RATIO: begin
               if (bus.wdata[RATIO_SEL_BIT]) begin
                  divider_ratio_o[3:2] <= bus.wdata[1:0];
               end else begin
                  divider_ratio_o[1:0] <= bus.wdata[1:0];
               end
            end
            LCD_OP_REF: ref_coef_o <= bus.wdata[1:0];
            LCD_OP_STEPUP: stepup_factor_o <= 3'h3 + {1'b0, bus.wdata[1:0]};
            LCD_OP_DUTY: duty_code <= bus.wdata[3:0];
            LCD_OP_RESET: divider_ratio_o <= RATIO_RESET;
            default: ;
         endcase
      end
   end

   // Pot lock and value, test and read/modify/write modes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pot_locked_o <= 1'b0;
         pot_value_o <= POT_RESET;
         test_mode_o <= 1'b0;
         rmw_mode_o <= 1'b0;
      end else begin
         case (op)
            LCD_OP_POT_MODE: pot_locked_o <= 1'b1;
            LCD_OP_POT_VAL: begin
               pot_value_o <= bus.wdata[5:0];
               pot_locked_o <= 1'b0;
            end
            LCD_OP_TEST: test_mode_o <= 1'b1;
            LCD_OP_RMW: rmw_mode_o <= 1'b1;
            LCD_OP_END: rmw_mode_o <= 1'b0;
            LCD_OP_RESET: begin
               pot_value_o <= POT_RESET;
               test_mode_o <= 1'b0;
               rmw_mode_o <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   // Addresses: start line, start common, page, column
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_line <= 7'h00;
         start_com <= 7'h00;
         page <= 4'h0;
         col <= 8'h00;
         col_saved <= 8'h00;
      end else begin
         case (op)
            LCD_OP_LINE_HI: start_line[6:4] <= bus.wdata[2:0];
            LCD_OP_LINE_LO: start_line[3:0] <= bus.wdata[3:0];
            LCD_OP_COM_HI: start_com[6:4] <= bus.wdata[2:0];
            LCD_OP_COM_LO: start_com[3:0] <= bus.wdata[3:0];
            LCD_OP_PAGE: page <= bus.wdata[3:0];
            LCD_OP_COL_HI: col[7:4] <= bus.wdata[3:0];
            LCD_OP_COL_LO: col[3:0] <= bus.wdata[3:0];
            LCD_OP_RMW: col_saved <= col;
            LCD_OP_END: col <= col_saved;
            LCD_OP_RESET: begin
               start_line <= 7'h00;
               start_com <= 7'h00;
               page <= 4'h0;
               col <= 8'h00;
            end
            default: begin
               if ((data_wr || (data_rd && !rmw_mode_o)) && col != COL_LAST) begin
                  col <= col + 8'h01;
               end
            end
         endcase
      end
   end

   // Display RAM write port, untouched by any reset
   always_ff @(posedge clk_i) begin
      if (data_wr && page_ok && col < 8'(NUM_COLS)) begin
         ram[ram_idx] <= bus.wdata;
      end
   end

   // Read path: data one access behind, status immediate
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_latch <= 8'h00;
         bus.rdata <= 8'h00;
         bus.rdata_oe_n <= 1'b1;
      end else begin
         bus.rdata_oe_n <= !bus.rd_stb;
         if (data_rd) begin
            bus.rdata <= read_latch;
            read_latch <= (page_ok && col < 8'(NUM_COLS)) ? ram[ram_idx] : 8'h00;
         end else if (stat_rd) begin
            bus.rdata <= {1'b0, !display_on_o, !seg_reverse_o, 1'b0, STATUS_LOW};
         end
      end
   end

   // Line tick divider, halted with the oscillator
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt <= 5'h00;
      end else if (osc_run_o) begin
         tick_cnt <= tick ? 5'h00 : tick_cnt + 5'h01;
      end
   end
   assign tick = tick_cnt == SCAN_TICK_CYCLES - 5'h01;

   // Derived outputs
   assign power_save_o = !display_on_o && all_lit_o;
   assign osc_run_o = !power_save_o;
   assign outputs_ground_o = power_save_o;
   assign stepup_on_o = power_bits[2] && !power_save_o;
   assign regulator_on_o = power_bits[1] && !power_save_o;
   assign follower_on_o = power_bits[0] && !power_save_o;
   assign gain_half_o = GAIN_BASE + {1'b0, divider_ratio_o};
   assign pot_index_o = ~pot_value_o;
   assign duty_lines_o = (duty_code > DUTY_LAST_CODE) ? DUTY_STEP :
      7'(NUM_LINES) - DUTY_STEP * {3'h0, duty_code};

   lcd_scan u_scan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .run_i(osc_run_o),
      .start_line_i(start_line),
      .start_com_i(start_com),
      .duty_lines_i(duty_lines_o),
      .com_rev_i(com_reverse_o),
      .line_o(scan_line_o),
      .com_o(scan_com_o)
   );
endmodule : lcd_device
`default_nettype wire

/* File: design/lcd_host.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_host
   import lcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   lcd_bus_if.host bus,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   lcd_host_e state;
   logic [7:0] last_read; // Byte of the latest read
   logic wb_req;
   logic cmd_go;
   logic rd_go;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cmd_go = wb_req && wb_we_i && wb_adr_i == HOST_CMD_ADR && wb_sel_i[0]
      && state == LCD_H_IDLE;
   assign rd_go = wb_req && wb_we_i && wb_adr_i == HOST_RD_ADR && state == LCD_H_IDLE;

   // Wishbone ack one cycle after request, read data with it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i && wb_adr_i == HOST_STAT_ADR) begin
            wb_dat_o <= {16'h0000, last_read, 7'h00, state != LCD_H_IDLE};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // Strobe sequencer; one strobe per request, pair order kept by software
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= LCD_H_IDLE;
         bus.register_select <= 1'b0;
         bus.wdata <= 8'h00;
         last_read <= 8'h00;
      end else begin
         case (state)
            LCD_H_IDLE: begin
               if (cmd_go) begin
                  bus.wdata <= wb_dat_i[7:0];
                  bus.register_select <= wb_dat_i[HOST_RS_BIT];
                  state <= LCD_H_WRITE;
               end else if (rd_go) begin
                  bus.register_select <= wb_dat_i[HOST_RS_BIT];
                  state <= LCD_H_READ;
               end
            end
            LCD_H_WRITE: state <= LCD_H_IDLE;
            LCD_H_READ: state <= LCD_H_WAIT;
            LCD_H_WAIT: begin
               if (!bus.rdata_oe_n) begin
                  last_read <= bus.rdata;
                  state <= LCD_H_IDLE;
               end
            end
            default: state <= LCD_H_IDLE;
         endcase
      end
   end

   assign bus.wr_stb = state == LCD_H_WRITE;
   assign bus.rd_stb = state == LCD_H_READ;
endmodule : lcd_host
`default_nettype wire

/* File: design/lcd_scan.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_scan
   import lcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,            // Line rate enable
   input wire logic run_i,             // Low halts scanning
   input wire logic [6:0] start_line_i,
   input wire logic [6:0] start_com_i,
   input wire logic [6:0] duty_lines_i,
   input wire logic com_rev_i,
   output logic [6:0] line_o,
   output logic [6:0] com_o
);
   logic [6:0] offset; // Lines since frame start
   logic [7:0] line_sum;
   logic [7:0] com_sum;
   logic [6:0] com_addr;

   // Offset walks the duty, then wraps to start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         offset <= 7'h00;
      end else if (run_i && tick_i) begin
         if (offset + 7'h01 >= duty_lines_i) begin
            offset <= 7'h00;
         end else begin
            offset <= offset + 7'h01;
         end
      end
   end

   // Addresses modulo the line count
   always_comb begin
      line_sum = {1'b0, start_line_i} + {1'b0, offset};
      com_sum = {1'b0, start_com_i} + {1'b0, offset};
      if (line_sum >= LINE_COUNT) begin
         line_sum = line_sum - LINE_COUNT;
      end
      if (com_sum >= LINE_COUNT) begin
         com_sum = com_sum - LINE_COUNT;
      end
      com_addr = com_sum[6:0];
   end

   // Registered scan outputs, direction applied to common
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_o <= 7'h00;
         com_o <= 7'h00;
      end else begin
         line_o <= line_sum[6:0];
         com_o <= com_rev_i ? (LINE_MAX - com_addr) : com_addr;
      end
   end
endmodule : lcd_scan
`default_nettype wire

/* File: inc/lcd_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface lcd_bus_if;
   logic register_select; // Low command, high display data
   logic wr_stb;          // One-cycle write strobe
   logic rd_stb;          // One-cycle read strobe
   logic [7:0] wdata;     // Host drive of data pins
   logic [7:0] rdata;     // Device drive of data pins
   logic rdata_oe_n;      // Low while device drives data

   modport device (input register_select, wr_stb, rd_stb, wdata, output rdata, rdata_oe_n);
   modport host (output register_select, wr_stb, rd_stb, wdata, input rdata, rdata_oe_n);
endinterface : lcd_bus_if
`default_nettype wire

/* File: inc/lcd_pkg.sv */
package lcd_pkg;
   // Panel geometry
   localparam int NUM_LINES = 80;
   localparam int NUM_COLS = 132;
   localparam int NUM_PAGES = 10;
   localparam int RAM_WORDS = NUM_PAGES * NUM_COLS;
   localparam logic [7:0] COL_LAST = 8'h83;
   localparam logic [7:0] LINE_COUNT = 8'h50;
   localparam logic [6:0] LINE_MAX = 7'h4f;
   localparam logic [6:0] DUTY_STEP = 7'h08;
   localparam logic [3:0] DUTY_LAST_CODE = 4'h9;
   // Reset values
   localparam logic [5:0] POT_RESET = 6'h20;
   localparam logic [3:0] RATIO_RESET = 4'h0;
   localparam logic [3:0] DUTY_RESET = 4'h0;
   localparam logic [4:0] GAIN_BASE = 5'h03;
   // Scan line tick divider, in clk_i cycles
   localparam logic [4:0] SCAN_TICK_CYCLES = 5'h10;
   // Command byte patterns, register_select low
   localparam logic [7:0] PAT_COL_LO = 8'b0000_????;
   localparam logic [7:0] PAT_COL_HI = 8'b0001_????;
   localparam logic [7:0] PAT_RATIO = 8'b0010_0???;
   localparam logic [7:0] PAT_POWER = 8'b0010_1???;
   localparam logic [7:0] PAT_REF = 8'b0011_0???;
   localparam logic [7:0] PAT_STEPUP = 8'b0011_1???;
   localparam logic [7:0] PAT_LINE_HI = 8'b0100_????;
   localparam logic [7:0] PAT_LINE_LO = 8'b0101_????;
   localparam logic [7:0] PAT_COM_HI = 8'b0110_????;
   localparam logic [7:0] PAT_COM_LO = 8'b0111_????;
   localparam logic [7:0] PAT_POT_MODE = 8'h81;
   localparam logic [7:0] PAT_DUTY = 8'b1001_????;
   localparam logic [7:0] PAT_SEG = 8'b1010_000?;
   localparam logic [7:0] PAT_ALL = 8'b1010_010?;
   localparam logic [7:0] PAT_INV = 8'b1010_011?;
   localparam logic [7:0] PAT_DISP = 8'b1010_111?;
   localparam logic [7:0] PAT_PAGE = 8'b1011_????;
   localparam logic [7:0] PAT_COMDIR = 8'b1100_????;
   localparam logic [7:0] PAT_RMW = 8'he0;
   localparam logic [7:0] PAT_RESET = 8'he2;
   localparam logic [7:0] PAT_NOP = 8'he3;
   localparam logic [7:0] PAT_END = 8'hee;
   localparam logic [7:0] PAT_TEST = 8'b1111_????;
   // Field positions
   localparam int RATIO_SEL_BIT = 2;
   localparam int COMDIR_BIT = 3;
   localparam logic [3:0] STATUS_LOW = 4'hf;
   // Host register offsets
   localparam logic [7:0] HOST_CMD_ADR = 8'h00;
   localparam logic [7:0] HOST_RD_ADR = 8'h04;
   localparam logic [7:0] HOST_STAT_ADR = 8'h08;
   localparam int HOST_RS_BIT = 8;

   // Decoded commands
   typedef enum logic [4:0] {
      LCD_OP_NONE, LCD_OP_COL_LO, LCD_OP_COL_HI, LCD_OP_RATIO, LCD_OP_POWER,
      LCD_OP_REF, LCD_OP_STEPUP, LCD_OP_LINE_HI, LCD_OP_LINE_LO, LCD_OP_COM_HI,
      LCD_OP_COM_LO, LCD_OP_POT_MODE, LCD_OP_POT_VAL, LCD_OP_DUTY, LCD_OP_SEG,
      LCD_OP_ALL, LCD_OP_INV, LCD_OP_DISP, LCD_OP_PAGE, LCD_OP_COMDIR,
      LCD_OP_RMW, LCD_OP_RESET, LCD_OP_NOP, LCD_OP_END, LCD_OP_TEST
   } lcd_op_e;

   // Host sequencer states
   typedef enum logic [1:0] {LCD_H_IDLE, LCD_H_WRITE, LCD_H_READ, LCD_H_WAIT} lcd_host_e;
endpackage : lcd_pkg

/* File: test/lcd_bus_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_bus_assertions
   import lcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic register_select,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wdata,
   input wire logic rdata_oe_n,
   input wire logic display_on_o,
   input wire logic all_lit_o,
   input wire logic power_save_o,
   input wire logic osc_run_o,
   input wire logic outputs_ground_o,
   input wire logic pot_locked_o,
   input wire logic [5:0] pot_value_o,
   input wire logic [5:0] pot_index_o,
   input wire logic [3:0] divider_ratio_o,
   input wire logic [4:0] gain_half_o
);
   logic [5:0] wdata_low; // Six value bits of the bus byte
   assign wdata_low = wdata[5:0];
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Unlocked command byte taken from the bus
   sequence s_cmd(logic [7:0] b);
      wr_stb && !register_select && wdata == b && !pot_locked_o;
   endsequence
   // Read reply window of exactly one cycle
   sequence s_read_reply;
      !rdata_oe_n ##1 rdata_oe_n;
   endsequence
   property p_read_reply;
      rd_stb |=> s_read_reply;
   endproperty
   a_read_reply: assert property (p_read_reply) else $error("read reply window wrong");
   property p_reply_cause;
      $fell(rdata_oe_n) |-> $past(rd_stb);
   endproperty
   a_reply_cause: assert property (p_reply_cause) else $error("data driven without read");
   property p_wr_pulse;
      wr_stb |=> !wr_stb;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
   property p_ps_enter;
      power_save_o == (!display_on_o && all_lit_o);
   endproperty
   a_ps_enter: assert property (p_ps_enter) else $error("power save state wrong");
   property p_ps_halt;
      power_save_o |-> !osc_run_o && outputs_ground_o;
   endproperty
   a_ps_halt: assert property (p_ps_halt) else $error("power save not halting");
   property p_pot_index;
      pot_locked_o && wr_stb && !register_select |=> pot_index_o == ~$past(wdata_low);
   endproperty
   a_pot_index: assert property (p_pot_index) else $error("level index not inverted");
   property p_gain;
      gain_half_o == GAIN_BASE + divider_ratio_o;
   endproperty
   a_gain: assert property (p_gain) else $error("gain does not follow ratio");
   property p_pot_lock;
      s_cmd(PAT_POT_MODE) |=> pot_locked_o;
   endproperty
   a_pot_lock: assert property (p_pot_lock) else $error("mode byte did not lock");
   property p_pot_store;
      pot_locked_o && wr_stb && !register_select |=>
         !pot_locked_o && pot_value_o == $past(wdata_low);
   endproperty
   a_pot_store: assert property (p_pot_store) else $error("value byte not stored");
   property p_all_off;
      s_cmd(8'ha4) |=> !power_save_o;
   endproperty
   a_all_off: assert property (p_all_off) else $error("power save not left");
endmodule : lcd_bus_assertions
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import lcd_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_o, q, snap;
   logic wb_ack_o, display_on_o, all_lit_o, inverse_o, seg_reverse_o, com_reverse_o;
   logic power_save_o, osc_run_o, outputs_ground_o, stepup_on_o, regulator_on_o;
   logic follower_on_o, pot_locked_o, rmw_mode_o, test_mode_o;
   logic [3:0] divider_ratio_o;
   logic [4:0] gain_half_o;
   logic [5:0] pot_value_o, pot_index_o;
   logic [1:0] ref_coef_o;
   logic [2:0] stepup_factor_o;
   logic [6:0] duty_lines_o, scan_line_o, scan_com_o, lo, hi, clo, chi;
   int n_mismatch = 0;
   int check_count = 0;
   // Free running clock
   always #10 clk_i = ~clk_i;
   lcd_bus_if lcd_bus_if_inst ();
   lcd_host lcd_host_inst (.clk_i, .rst_i, .bus(lcd_bus_if_inst), .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o);
   lcd_device lcd_device_inst (.clk_i, .rst_i, .bus(lcd_bus_if_inst), .display_on_o,
      .all_lit_o, .inverse_o, .seg_reverse_o, .com_reverse_o, .power_save_o, .osc_run_o,
      .outputs_ground_o, .stepup_on_o, .regulator_on_o, .follower_on_o, .divider_ratio_o,
      .gain_half_o, .pot_value_o, .pot_index_o, .pot_locked_o, .ref_coef_o,
      .stepup_factor_o, .duty_lines_o, .rmw_mode_o, .test_mode_o, .scan_line_o, .scan_com_o);
   lcd_bus_assertions lcd_bus_assertions_inst (.clk_i, .rst_i,
      .register_select(lcd_bus_if_inst.register_select), .wr_stb(lcd_bus_if_inst.wr_stb),
      .rd_stb(lcd_bus_if_inst.rd_stb), .wdata(lcd_bus_if_inst.wdata),
      .rdata_oe_n(lcd_bus_if_inst.rdata_oe_n), .display_on_o, .all_lit_o, .power_save_o,
      .osc_run_o, .outputs_ground_o, .pot_locked_o, .pot_value_o, .pot_index_o,
      .divider_ratio_o, .gain_half_o);
   // Counts and reports one comparison
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One classic Wishbone cycle, held until ack is sampled
   task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb_xfer
   // Polls status until the host side is idle
   task wait_idle;
      int n;
      n = 0;
      do begin
         wb_xfer(1'b0, HOST_STAT_ADR, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 10);
      if (q[0] !== 1'b0) n_mismatch++;
   endtask : wait_idle
   // Sends one byte, command or display data
   task send(input logic rs, input logic [7:0] b);
      wb_xfer(1'b1, HOST_CMD_ADR, {23'h0, rs, b});
      wait_idle();
   endtask : send
   // Display data read; read byte left in q[15:8]
   task rd_data;
      wb_xfer(1'b1, HOST_RD_ADR, 32'h100);
      wait_idle();
   endtask : rd_data
   // Tracks scan address extremes over a span of cycles
   task scan_span(input int cycles);
      lo = 7'h7f;
      hi = 7'h00;
      clo = 7'h7f;
      chi = 7'h00;
      repeat (cycles) begin
         @(posedge clk_i);
         if (scan_line_o < lo) lo = scan_line_o;
         if (scan_line_o > hi) hi = scan_line_o;
         if (scan_com_o < clo) clo = scan_com_o;
         if (scan_com_o > chi) chi = scan_com_o;
      end
   endtask : scan_span
   // Prints counts and verdict, ends the run
   task wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      check(pot_value_o, 6'h20);
      check(duty_lines_o, 7'h50);
      for (int i = 0; i < 8; i++) begin
         send(1'b0, 8'h28 | i[7:0]);
         check({stepup_on_o, regulator_on_o, follower_on_o}, i);
      end
      for (int i = 0; i < 16; i++) begin
         send(1'b0, 8'h24 | i[3:2]);
         send(1'b0, 8'h20 | i[1:0]);
         check(divider_ratio_o, i);
         check(gain_half_o, 3 + i);
      end
      for (int i = 0; i < 4; i++) begin
         send(1'b0, 8'h34 | i[1:0]);
         check(ref_coef_o, i);
         send(1'b0, 8'h3c | i[1:0]);
         check(stepup_factor_o, 3 + i);
      end
      for (int i = 0; i < 10; i++) begin
         send(1'b0, 8'h90 | i[3:0]);
         check(duty_lines_o, 80 - 8 * i);
      end
      // Locked pair: a display-on byte becomes the value
      send(1'b0, PAT_POT_MODE);
      check(pot_locked_o, 1'b1);
      send(1'b0, 8'haf);
      check({pot_locked_o, display_on_o, pot_value_o}, 8'h2f);
      check(pot_index_o, 6'h10);
      send(1'b0, PAT_POT_MODE);
      send(1'b0, 8'hc0);
      check(pot_index_o, 6'h3f);
      send(1'b0, 8'haf);
      check(display_on_o, 1'b1);
      send(1'b0, 8'hae);
      check(display_on_o, 1'b0);
      send(1'b0, 8'hc8);
      check(com_reverse_o, 1'b1);
      send(1'b0, 8'hc0);
      check(com_reverse_o, 1'b0);
      for (int i = 0; i < 4; i++) begin
         send(1'b0, 8'hae | i[1]);
         send(1'b0, 8'ha4 | i[0]);
         check(power_save_o, ~i[1] & i[0]);
      end
      send(1'b0, 8'hae);
      check({power_save_o, osc_run_o, outputs_ground_o, stepup_on_o}, 4'ha);
      // Display RAM stays usable in power save
      send(1'b0, 8'hb0);
      send(1'b0, 8'h10);
      send(1'b0, 8'h00);
      send(1'b1, 8'h5a);
      send(1'b1, 8'hc3);
      send(1'b0, 8'h10);
      send(1'b0, 8'h00);
      rd_data();
      rd_data();
      check(q[15:8], 8'h5a);
      rd_data();
      check(q[15:8], 8'hc3);
      send(1'b0, 8'ha4);
      check({power_save_o, stepup_on_o, divider_ratio_o}, 6'h1f);
      snap = {divider_ratio_o, pot_value_o, duty_lines_o, stepup_factor_o, ref_coef_o};
      send(1'b0, PAT_NOP);
      check({divider_ratio_o, pot_value_o, duty_lines_o, stepup_factor_o, ref_coef_o}, snap);
      send(1'b0, 8'haf);
      send(1'b0, PAT_RMW);
      check(rmw_mode_o, 1'b1);
      send(1'b0, PAT_RESET);
      check({rmw_mode_o, divider_ratio_o, pot_value_o}, 11'h020);
      check(display_on_o, 1'b1);
      // Inverse and segment order, then status byte
      send(1'b0, 8'ha7);
      send(1'b0, 8'ha1);
      check({inverse_o, seg_reverse_o}, 2'h3);
      wb_xfer(1'b1, HOST_RD_ADR, 32'h0);
      wait_idle();
      check(q[15:8], 8'h0f);
      // Unmapped host offset reads zero
      wb_xfer(1'b0, 8'h40, 32'h0);
      check(q, 32'h0);
      // Eight-line scan from line 5 and common 3
      send(1'b0, 8'h99);
      send(1'b0, 8'h40);
      send(1'b0, 8'h55);
      send(1'b0, 8'h60);
      send(1'b0, 8'h73);
      repeat (100) @(posedge clk_i);
      scan_span(320);
      check({lo, hi}, {7'h05, 7'h0c});
      check({clo, chi}, {7'h03, 7'h0a});
      // Reversed common scan mirrors the same eight lines
      send(1'b0, 8'hc8);
      repeat (40) @(posedge clk_i);
      scan_span(160);
      check({lo, hi}, {7'h05, 7'h0c});
      check({clo, chi}, {7'h45, 7'h4c});
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
